/* tpbx_pkg.sv */
/*
 * shared constants for the three-port bus exchanger.
 * assumes one 50 MHz system clock; all port pins are asynchronous to it.
 */
package tpbx_pkg;

    // ***************************************************************
    // widths and indices
    // ***************************************************************
    localparam int TPBX_WIDTH = 18;
    localparam int TPBX_PORTS = 3;
    localparam int TPBX_IDX_A = 0;
    localparam int TPBX_IDX_B = 1;
    localparam int TPBX_IDX_C = 2;

    // ***************************************************************
    // reset values
    // ***************************************************************
    localparam logic [17:0] TPBX_STORE_RST = 18'h00000;
    localparam logic [17:0] TPBX_OUT_RST = 18'h00000;
    localparam logic TPBX_DRIVE_RST = 1'b0;
    // drive enable pins idle released, matching a pulled-up enable
    localparam logic TPBX_OE_N_RST = 1'b1;

    // ***************************************************************
    // timing: synchroniser depth and pin-to-pin latency in cycles
    // ***************************************************************
    localparam int TPBX_SYNC_STAGES = 2;
    localparam int TPBX_STORE_LATENCY = 3;
    localparam int TPBX_OUT_LATENCY = 4;

endpackage

/* tpbx_exchanger.sv */
/*
 * three-port bus exchanger: per-port storage element (transparent, held or
 * edge-captured) and per-port output selection from the other two elements.
 * assumes: every port pin is asynchronous to CLOCK and is synchronised here; the
 * capture clocks stay high and low for at least two CLOCK periods each; the
 * testbench resolves each two-way port from its output and output enable.
 */
`timescale 1ns/1ns

module tpbx_exchanger
    import tpbx_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic [17:0] PORT_A_IN,
    output logic [17:0] PORT_A_OUT,
    output logic PORT_A_OE,
    input wire logic [17:0] PORT_B_IN,
    output logic [17:0] PORT_B_OUT,
    output logic PORT_B_OE,
    input wire logic [17:0] PORT_C_IN,
    output logic [17:0] PORT_C_OUT,
    output logic PORT_C_OE,
    input wire logic PORT_A_DRIVE_ENABLE_N,
    input wire logic PORT_B_DRIVE_ENABLE_N,
    input wire logic PORT_C_DRIVE_ENABLE_N,
    input wire logic PORT_A_SOURCE_SELECT,
    input wire logic PORT_B_SOURCE_SELECT,
    input wire logic PORT_C_SOURCE_SELECT,
    input wire logic PORT_A_TRANSPARENT,
    input wire logic PORT_B_TRANSPARENT,
    input wire logic PORT_C_TRANSPARENT,
    input wire logic PORT_A_CAPTURE_CLOCK,
    input wire logic PORT_B_CAPTURE_CLOCK,
    input wire logic PORT_C_CAPTURE_CLOCK
);

    // ***************************************************************
    // functions
    // ***************************************************************
    // storage element next value
    function automatic logic [17:0] store_next(
        input logic transparent,
        input logic rise,
        input logic [17:0] pins,
        input logic [17:0] held
    );
        logic [17:0] res;
        res = held;
        if (transparent) begin
            res = pins;
        end else if (rise) begin
            res = pins;
        end
        return res;
    endfunction

    // two-way source pick for an output port
    function automatic logic [17:0] pick_source(
        input logic sel,
        input logic [17:0] src_high,
        input logic [17:0] src_low
    );
        return sel ? src_high : src_low;
    endfunction

    // ***************************************************************
    // pin gathering
    // ***************************************************************
    wire [17:0] pins_raw [TPBX_PORTS];
    wire [TPBX_PORTS-1:0] oe_n_raw;
    wire [TPBX_PORTS-1:0] sel_raw;
    wire [TPBX_PORTS-1:0] le_raw;
    wire [TPBX_PORTS-1:0] clk_raw;

    // pins are the resolved wire level, so a driving port sees its own value
    assign pins_raw[TPBX_IDX_A] = PORT_A_IN;
    assign pins_raw[TPBX_IDX_B] = PORT_B_IN;
    assign pins_raw[TPBX_IDX_C] = PORT_C_IN;
    assign oe_n_raw = {PORT_C_DRIVE_ENABLE_N, PORT_B_DRIVE_ENABLE_N, PORT_A_DRIVE_ENABLE_N};
    assign sel_raw = {PORT_C_SOURCE_SELECT, PORT_B_SOURCE_SELECT, PORT_A_SOURCE_SELECT};
    assign le_raw = {PORT_C_TRANSPARENT, PORT_B_TRANSPARENT, PORT_A_TRANSPARENT};
    assign clk_raw = {PORT_C_CAPTURE_CLOCK, PORT_B_CAPTURE_CLOCK, PORT_A_CAPTURE_CLOCK};

    // ***************************************************************
    // synchronisers
    // ***************************************************************
    // data and controls share one depth so a capture edge samples data of the same instant
    logic [17:0] pins_meta_reg [TPBX_PORTS];
    logic [17:0] pins_s_reg [TPBX_PORTS];
    logic [TPBX_PORTS-1:0] oe_n_meta_reg, oe_n_s_reg;
    logic [TPBX_PORTS-1:0] sel_meta_reg, sel_s_reg;
    logic [TPBX_PORTS-1:0] le_meta_reg, le_s_reg;
    logic [TPBX_PORTS-1:0] clk_meta_reg, clk_s_reg, clk_prev_reg;

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int p = 0; p < TPBX_PORTS; p++) begin
                pins_meta_reg[p] <= TPBX_STORE_RST;
                pins_s_reg[p] <= TPBX_STORE_RST;
            end
            oe_n_meta_reg <= {TPBX_PORTS{TPBX_OE_N_RST}};
            oe_n_s_reg <= {TPBX_PORTS{TPBX_OE_N_RST}};
            sel_meta_reg <= '0;
            sel_s_reg <= '0;
            le_meta_reg <= '0;
            le_s_reg <= '0;
            clk_meta_reg <= '0;
            clk_s_reg <= '0;
            clk_prev_reg <= '0;
        end else begin
            for (int p = 0; p < TPBX_PORTS; p++) begin
                pins_meta_reg[p] <= pins_raw[p];
                pins_s_reg[p] <= pins_meta_reg[p];
            end
            oe_n_meta_reg <= oe_n_raw;
            oe_n_s_reg <= oe_n_meta_reg;
            sel_meta_reg <= sel_raw;
            sel_s_reg <= sel_meta_reg;
            le_meta_reg <= le_raw;
            le_s_reg <= le_meta_reg;
            clk_meta_reg <= clk_raw;
            clk_s_reg <= clk_meta_reg;
            clk_prev_reg <= clk_s_reg;
        end
    end

    // ***************************************************************
    // storage elements
    // ***************************************************************
    // each port uses only its own clock and transparent input
    wire [TPBX_PORTS-1:0] clk_rise = clk_s_reg & ~clk_prev_reg;
    logic [17:0] store_reg [TPBX_PORTS];
    logic [17:0] store_next_w [TPBX_PORTS];

    always_comb begin
        for (int p = 0; p < TPBX_PORTS; p++) begin
            // transparent follows pins rising edge captures
            // otherwise hold
            store_next_w[p] = store_next(le_s_reg[p], clk_rise[p], pins_s_reg[p], store_reg[p]);
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int p = 0; p < TPBX_PORTS; p++) begin
                store_reg[p] <= TPBX_STORE_RST;
            end
        end else begin
            for (int p = 0; p < TPBX_PORTS; p++) begin
                store_reg[p] <= store_next_w[p];
            end
        end
    end

    // ***************************************************************
    // output selection
    // ***************************************************************
    // one element may feed both other ports at once
    wire [17:0] src_a = pick_source(sel_s_reg[TPBX_IDX_A], store_reg[TPBX_IDX_C],
                                    store_reg[TPBX_IDX_B]);
    wire [17:0] src_b = pick_source(sel_s_reg[TPBX_IDX_B], store_reg[TPBX_IDX_A],
                                    store_reg[TPBX_IDX_C]);
    wire [17:0] src_c = pick_source(sel_s_reg[TPBX_IDX_C], store_reg[TPBX_IDX_B],
                                    store_reg[TPBX_IDX_A]);
    wire [TPBX_PORTS-1:0] drive_next = ~oe_n_s_reg;

    logic [17:0] out_a_reg, out_b_reg, out_c_reg;
    logic [TPBX_PORTS-1:0] drive_reg;

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            out_a_reg <= TPBX_OUT_RST;
            out_b_reg <= TPBX_OUT_RST;
            out_c_reg <= TPBX_OUT_RST;
            drive_reg <= {TPBX_PORTS{TPBX_DRIVE_RST}};
        end else begin
            // data keeps tracking while released; only the enable gates the pin
            out_a_reg <= src_a;
            out_b_reg <= src_b;
            out_c_reg <= src_c;
            drive_reg <= drive_next;
        end
    end

    assign PORT_A_OUT = out_a_reg;
    assign PORT_B_OUT = out_b_reg;
    assign PORT_C_OUT = out_c_reg;
    assign PORT_A_OE = drive_reg[TPBX_IDX_A];
    assign PORT_B_OE = drive_reg[TPBX_IDX_B];
    assign PORT_C_OE = drive_reg[TPBX_IDX_C];

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    a_release_when_off: assert property (
        oe_n_s_reg[TPBX_IDX_A] |=> !PORT_A_OE)
        else $error("port a drives while its enable is high");

    a_drive_when_on: assert property (
        !oe_n_s_reg[TPBX_IDX_C] |=> PORT_C_OE)
        else $error("port c released while its enable is low");

    a_port_a_mux: assert property (
        !oe_n_s_reg[TPBX_IDX_A] |=> PORT_A_OUT == ($past(sel_s_reg[TPBX_IDX_A]) ?
            $past(store_reg[TPBX_IDX_C]) : $past(store_reg[TPBX_IDX_B])))
        else $error("port a drives the wrong element");

    a_port_b_mux: assert property (
        !oe_n_s_reg[TPBX_IDX_B] && sel_s_reg[TPBX_IDX_B]
        |=> PORT_B_OE && PORT_B_OUT == $past(store_reg[TPBX_IDX_A]))
        else $error("port b high select does not drive the a element");

    a_port_c_mux: assert property (
        !oe_n_s_reg[TPBX_IDX_C] && !sel_s_reg[TPBX_IDX_C]
        |=> PORT_C_OUT == $past(store_reg[TPBX_IDX_A]))
        else $error("port c low select does not drive the a element");

    a_fanout_both: assert property (
        sel_s_reg[TPBX_IDX_B] && !sel_s_reg[TPBX_IDX_C] |=> PORT_B_OUT == PORT_C_OUT)
        else $error("a element not delivered to both b and c");

    a_transparent_follow: assert property (
        le_s_reg[TPBX_IDX_A] |=> store_reg[TPBX_IDX_A] == $past(pins_s_reg[TPBX_IDX_A]))
        else $error("port a element not transparent");

    a_hold_steady: assert property (
        !le_s_reg[TPBX_IDX_C] && clk_s_reg[TPBX_IDX_C] == clk_prev_reg[TPBX_IDX_C]
        |=> $stable(store_reg[TPBX_IDX_C]))
        else $error("port c element changed while held");

    a_edge_capture: assert property (
        !le_s_reg[TPBX_IDX_A] && clk_s_reg[TPBX_IDX_A] && !clk_prev_reg[TPBX_IDX_A]
        |=> store_reg[TPBX_IDX_A] == $past(pins_s_reg[TPBX_IDX_A]))
        else $error("port a element missed a capture edge");

    a_own_clock_b: assert property (
        !le_s_reg[TPBX_IDX_B] && !(clk_s_reg[TPBX_IDX_B] && !clk_prev_reg[TPBX_IDX_B])
        |=> store_reg[TPBX_IDX_B] == $past(store_reg[TPBX_IDX_B]))
        else $error("port b element moved without its own edge");

    a_pin_to_pin: assert property (
        $rose(PORT_A_TRANSPARENT) ##0 PORT_A_TRANSPARENT [*4] |->
        store_reg[TPBX_IDX_A] == $past(PORT_A_IN, 3))
        else $error("port a element does not reflect its own pins");

    a_release_b: assert property (
        oe_n_s_reg[TPBX_IDX_B] |=> !PORT_B_OE)
        else $error("port b drives while its enable is high");

    a_release_c: assert property (
        oe_n_s_reg[TPBX_IDX_C] |=> !PORT_C_OE)
        else $error("port c drives while its enable is high");

    a_drive_a: assert property (
        !oe_n_s_reg[TPBX_IDX_A] |=> PORT_A_OE)
        else $error("port a released while its enable is low");

    a_drive_b: assert property (
        !oe_n_s_reg[TPBX_IDX_B] |=> PORT_B_OE)
        else $error("port b released while its enable is low");

    a_port_b_low: assert property (
        !oe_n_s_reg[TPBX_IDX_B] && !sel_s_reg[TPBX_IDX_B]
        |=> PORT_B_OE && PORT_B_OUT == $past(store_reg[TPBX_IDX_C]))
        else $error("port b low select does not drive the c element");

    a_port_c_high: assert property (
        !oe_n_s_reg[TPBX_IDX_C] && sel_s_reg[TPBX_IDX_C]
        |=> PORT_C_OE && PORT_C_OUT == $past(store_reg[TPBX_IDX_B]))
        else $error("port c high select does not drive the b element");

    a_transparent_b: assert property (
        le_s_reg[TPBX_IDX_B] |=> store_reg[TPBX_IDX_B] == $past(pins_s_reg[TPBX_IDX_B]))
        else $error("port b element not transparent");

    a_transparent_c: assert property (
        le_s_reg[TPBX_IDX_C] |=> store_reg[TPBX_IDX_C] == $past(pins_s_reg[TPBX_IDX_C]))
        else $error("port c element not transparent");

    a_edge_capture_b: assert property (
        !le_s_reg[TPBX_IDX_B] && clk_s_reg[TPBX_IDX_B] && !clk_prev_reg[TPBX_IDX_B]
        |=> store_reg[TPBX_IDX_B] == $past(pins_s_reg[TPBX_IDX_B]))
        else $error("port b element missed a capture edge");

    a_edge_capture_c: assert property (
        !le_s_reg[TPBX_IDX_C] && clk_s_reg[TPBX_IDX_C] && !clk_prev_reg[TPBX_IDX_C]
        |=> store_reg[TPBX_IDX_C] == $past(pins_s_reg[TPBX_IDX_C]))
        else $error("port c element missed a capture edge");

    a_hold_steady_a: assert property (
        !le_s_reg[TPBX_IDX_A] && clk_s_reg[TPBX_IDX_A] == clk_prev_reg[TPBX_IDX_A]
        |=> $stable(store_reg[TPBX_IDX_A]))
        else $error("port a element changed while held");

    // with nobody contending, a driving port's resolved pins carry its own output
    a_own_pins_b: assert property (
        (PORT_B_OE && PORT_B_TRANSPARENT) [*4]
        |-> store_reg[TPBX_IDX_B] == $past(PORT_B_OUT, 3))
        else $error("port b element does not hold its own driven level");

endmodule

/* tpbx_bus_model.sv */
/*
 * outside bus logic on one two-way port of the exchanger.
 * assumes the testbench says when it drives; resolves the wire for the design.
 */
`timescale 1ns/1ns

module tpbx_bus_model (
    input wire logic clock,
    input wire logic [17:0] dev_out,
    input wire logic dev_oe,
    input wire logic [17:0] ext_val,
    input wire logic ext_on,
    output logic [17:0] pin
);
    // ***************************************************************
    // wire resolution
    // ***************************************************************
    // no pull on the data lines: a released bus flips every cycle so a
    // storage element that wrongly follows it is caught
    logic [17:0] float_reg = 18'h2aaaa;
    logic [17:0] float_next;
    // ext_on only ever rises while dev_oe is low
    assign pin = (dev_oe && ext_on) ? 18'hxxxxx : dev_oe ? dev_out : ext_on ? ext_val : float_reg;
    // an unknown enable before reset must not poison the floating value
    assign float_next = (dev_oe === 1'b1 || ext_on === 1'b1) ? ~pin : ~float_reg;
    always_ff @(posedge clock) begin
        float_reg <= float_next;
    end
endmodule

/* tb.sv */
/*
 * self-checking testbench for the three-port exchanger.
 * assumes tpbx_pkg and tpbx_bus_model are compiled first.
 */
`timescale 1ns/1ns

module tb;
    import tpbx_pkg::*;
    typedef struct {int port; logic oe; logic [17:0] val;} tpbx_note_t;
    logic clock;
    logic sys_rst;
    logic en_n [3];
    logic sel [3];
    logic le [3];
    logic cclk [3];
    logic ext_on [3];
    logic [17:0] ext_val [3];
    logic [17:0] elem [3];
    logic [17:0] dout [3];
    logic doe [3];
    wire logic [17:0] pin [3];
    logic check_req;
    logic [31:0] rng = 32'h0000000f;
    int fail_count = 0;
    int checks_done = 0;
    tpbx_note_t notes [$];

    // ***************************************************************
    // design and bus side
    // ***************************************************************
    tpbx_exchanger i_dut (.CLOCK(clock), .SYS_RST(sys_rst),
        .PORT_A_IN(pin[0]), .PORT_A_OUT(dout[0]), .PORT_A_OE(doe[0]),
        .PORT_B_IN(pin[1]), .PORT_B_OUT(dout[1]), .PORT_B_OE(doe[1]),
        .PORT_C_IN(pin[2]), .PORT_C_OUT(dout[2]), .PORT_C_OE(doe[2]),
        .PORT_A_DRIVE_ENABLE_N(en_n[0]), .PORT_B_DRIVE_ENABLE_N(en_n[1]),
        .PORT_C_DRIVE_ENABLE_N(en_n[2]), .PORT_A_SOURCE_SELECT(sel[0]),
        .PORT_B_SOURCE_SELECT(sel[1]), .PORT_C_SOURCE_SELECT(sel[2]),
        .PORT_A_TRANSPARENT(le[0]), .PORT_B_TRANSPARENT(le[1]), .PORT_C_TRANSPARENT(le[2]),
        .PORT_A_CAPTURE_CLOCK(cclk[0]), .PORT_B_CAPTURE_CLOCK(cclk[1]),
        .PORT_C_CAPTURE_CLOCK(cclk[2]));
    for (genvar g = 0; g < 3; g++) begin : g_bus
        tpbx_bus_model i_bus (.clock(clock), .dev_out(dout[g]), .dev_oe(doe[g]),
            .ext_val(ext_val[g]), .ext_on(ext_on[g]), .pin(pin[g]));
    end

    // ***************************************************************
    // helpers
    // ***************************************************************
    function automatic logic [17:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[17:0];
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // the source of port p is the other element chosen by its select
    task automatic expect_all();
        for (int p = 0; p < 3; p++) begin
            int s;
            s = sel[p] ? (p + 2) % 3 : (p + 1) % 3;
            notes.push_back('{p, !en_n[p], elem[s]});
        end
        check_req = 1'b1;
        step(1);
        check_req = 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ***************************************************************
    // clock, monitor, watchdog
    // ***************************************************************
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(negedge clock) begin
        tpbx_note_t n;
        if (check_req === 1'b1) begin
            while (notes.size() > 0) begin
                n = notes.pop_front();
                check({17'h0, doe[n.port]}, {17'h0, n.oe});
                check(dout[n.port], n.val);
            end
        end
    end
    initial begin
        #(5000 * 20);
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end

    // ***************************************************************
    // stimulus
    // ***************************************************************
    initial begin
        sys_rst = 1'b1;
        check_req = 1'b0;
        for (int p = 0; p < 3; p++) begin
            // every control at a defined level from time zero
            en_n[p] = 1'b1;
            sel[p] = 1'b0;
            le[p] = 1'b0;
            cclk[p] = 1'b0;
            ext_on[p] = 1'b0;
            ext_val[p] = 18'h00000;
            elem[p] = TPBX_STORE_RST;
        end
        step(3);
        sys_rst = 1'b0;
        step(2);
        expect_all();
        $display("test reset done");
        for (int p = 0; p < 3; p++) begin
            ext_val[p] = rnd();
            ext_on[p] = 1'b1;
            le[p] = 1'b1;
            elem[p] = ext_val[p];
        end
        step(6);
        for (int p = 0; p < 3; p++) le[p] = 1'b0;
        step(4);
        // bus released long before any enable falls
        for (int p = 0; p < 3; p++) ext_on[p] = 1'b0;
        step(8); // floating pins must not disturb held elements
        for (int i = 0; i < 16; i++) begin
            for (int p = 0; p < 3; p++) begin
                sel[p] = i[p];
                en_n[p] = i[3];
            end
            step(6);
            expect_all();
        end
        $display("test select table done");
        for (int p = 0; p < 3; p++) begin
            ext_val[p] = rnd();
            ext_on[p] = 1'b1;
            step(3);
            cclk[p] = 1'b1;
            elem[p] = ext_val[p];
            step(3);
            ext_val[p] = ~ext_val[p]; // held while the clock stays high
            step(3);
            cclk[p] = 1'b0;
            step(3);
            ext_val[p] = rnd(); // held while the clock stays low
            step(4);
            ext_on[p] = 1'b0;
        end
        for (int k = 0; k < 2; k++) begin
            for (int p = 0; p < 3; p++) begin
                sel[p] = k[0];
                en_n[p] = 1'b0;
            end
            step(6);
            expect_all();
        end
        $display("test edge capture done");
        // port b captures its own driven level while transparent
        sel[1] = 1'b1;
        le[1] = 1'b1;
        sel[2] = 1'b1;
        elem[1] = elem[0];
        step(10);
        expect_all();
        le[1] = 1'b0;
        step(4);
        for (int p = 0; p < 3; p++) en_n[p] = 1'b1;
        step(6);
        expect_all();
        $display("test own port capture done");
        final_report();
    end
endmodule
